// File: logic/map_store.sv
/*
  Breakpoint store for the per-channel maps: 64 words of 16 bits.
  Assumes one writer and one reader on the same clock; read data registered.
*/
`timescale 1ns/1ps
`default_nettype none
module map_store (
   input  wire logic        clock,
   input  wire logic        write_en,
   input  wire logic [5:0]  write_addr,
   input  wire logic [15:0] write_data,
   input  wire logic [5:0]  read_addr,
   output logic [15:0]      read_data
);
   // ==================================================================
   // storage, no reset so it maps onto ram
   logic [15:0] mem [64];

   always_ff @(posedge clock) begin
      if (write_en) begin
         mem[write_addr] <= write_data;
      end
      read_data <= mem[read_addr];
   end
endmodule
`default_nettype wire

// File: logic/pwm_output_efuse_channel.sv
/*
  Four half-bridge pwm output channels with electronic fuse, retry and
  map lookup. Assumes current samples in mA, synchronous to clock.
*/
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_efuse_channel #(
   parameter int unsigned MS_CYCLES = pwm_efuse_pkg::MS_CYCLES_DEFAULT
) (
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   input  wire pwm_efuse_pkg::reg_req_t bus,
   output logic [31:0]                  read_data,
   input  wire pwm_efuse_pkg::current_t current,
   output pwm_efuse_pkg::drive_t        drive,
   output logic [3:0]                   channel_fault
);
   import pwm_efuse_pkg::*;

   // ==================================================================
   // state
   typedef struct packed {
      chan_fsm_t   fsm;
      logic [7:0]  inrush_cnt;
      logic [17:0] us_cnt;
      logic [13:0] ms_cnt;
      logic [7:0]  over_cnt;
      logic [11:0] wait_cnt;
      logic [3:0]  retries;
      logic [2:0]  cause;
      logic [16:0] peak;
      logic [31:0] phase;
      logic [15:0] map_out;
      control_t    ctl;
      fuse_t       fuse;
      timing_t     tim;
      pwm_cfg_t    pwm;
      map_cfg_t    map;
   } chan_t;

   typedef struct packed {
      chan_t [NUM_CH-1:0] ch;
      drive_t             drv;
      logic [15:0]        ms_div;
      logic [3:0]         us_div;
      logic               ms_tick;
      logic               us_tick;
      logic [31:0]        rdata;
      logic [1:0]         lk_ch;
      logic [1:0]         lk_step;
      logic [15:0]        y0;
      logic [15:0]        y1;
      logic               mem_we;
      logic [5:0]         mem_waddr;
      logic [15:0]        mem_wdata;
   } state_t;

   state_t      s;
   state_t      next_s;
   logic [15:0] mem_rdata;
   logic [5:0]  mem_raddr;

   map_store u_map (
      .clock      (clock),
      .write_en   (s.mem_we),
      .write_addr (s.mem_waddr),
      .write_data (s.mem_wdata),
      .read_addr  (mem_raddr),
      .read_data  (mem_rdata)
   );

   // ==================================================================
   // breakpoint lookup: axis spacing is a power of two, so no divider
   map_cfg_t    lk_cfg;
   pwm_type_t   lk_type;
   logic [15:0] lk_idx;
   logic        lk_end;
   logic [3:0]  lk_i0;
   logic [3:0]  lk_i1;
   logic [15:0] lk_frac;
   logic        lk_up;
   logic [15:0] lk_dy;
   logic [31:0] lk_prod;
   logic [15:0] lk_adj;
   logic        lk_half;
   logic [15:0] lk_result;

   assign lk_cfg    = s.ch[s.lk_ch].map;
   assign lk_type   = s.ch[s.lk_ch].ctl.pwm_type;
   assign lk_idx    = lk_cfg.map_input >> lk_cfg.axis_shift;
   assign lk_end    = lk_idx >= 16'h000f;
   assign lk_i0     = lk_end ? 4'hf : lk_idx[3:0];
   assign lk_i1     = lk_end ? 4'hf : lk_i0 + 4'h1;
   assign lk_frac   = lk_end ? 16'h0000 : lk_cfg.map_input - 16'(lk_idx << lk_cfg.axis_shift);
   assign mem_raddr = {s.lk_ch, (s.lk_step == 2'd0) ? lk_i0 : lk_i1};
   assign lk_up     = s.y1 >= s.y0;
   assign lk_dy     = lk_up ? s.y1 - s.y0 : s.y0 - s.y1;
   assign lk_prod   = 32'(lk_dy) * 32'(lk_frac);
   assign lk_adj    = 16'(lk_prod >> lk_cfg.axis_shift);
   assign lk_half   = {lk_frac, 1'b0} >= 17'(17'h00001 << lk_cfg.axis_shift);

   always_comb begin
      unique case (lk_type[1:0])
         2'd0: lk_result = lk_up ? s.y0 + lk_adj : s.y0 - lk_adj;
         2'd1: lk_result = s.y0;
         2'd2: lk_result = (lk_frac != 16'h0000) ? s.y1 : s.y0;
         2'd3: lk_result = lk_half ? s.y1 : s.y0;
      endcase
   end

   // ==================================================================
   // applied duty and frequency per channel
   logic [6:0]  duty_app [NUM_CH];
   logic [14:0] freq_app [NUM_CH];
   logic [14:0] freq_own [NUM_CH];
   logic [31:0] phase_inc [NUM_CH];
   logic        type_ok [NUM_CH];

   for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
      pwm_type_t   ty;
      logic        is_duty;
      logic        is_freq;
      logic [15:0] f_raw;
      logic [6:0]  d_raw;
      assign ty      = s.ch[gi].ctl.pwm_type;
      assign is_duty = ty[3:2] == 2'b01;
      assign is_freq = ty[3:2] == 2'b10;
      assign f_raw   = is_freq ? s.ch[gi].map_out : {1'b0, s.ch[gi].pwm.freq_hz};
      assign freq_own[gi] = (f_raw < 16'(FREQ_MIN_HZ)) ? FREQ_MIN_HZ :
                            (f_raw > 16'(FREQ_MAX_HZ)) ? FREQ_MAX_HZ : f_raw[14:0];
      if (gi == 1) begin : g_shared
         assign freq_app[gi] = freq_app[0];
      end else begin : g_own
         assign freq_app[gi] = freq_own[gi];
      end
      assign d_raw = is_duty ? ((s.ch[gi].map_out > 16'(DUTY_FULL)) ? DUTY_FULL
                                                 : s.ch[gi].map_out[6:0])
                             : s.ch[gi].pwm.duty_pct;
      // a digital output ignores duty and conducts for the whole period
      assign duty_app[gi] = (ty == DIG_OUT) ? DUTY_FULL :
                            (d_raw > DUTY_FULL) ? DUTY_FULL : d_raw;
      assign type_ok[gi]  = (ty == DIG_OUT) || is_duty ||
                            (is_freq && gi >= 2);
      assign phase_inc[gi] = 32'((40'(freq_app[gi]) * 40'(PHASE_SCALE)) >> 16);
   end

   // ==================================================================
   // next state
   chan_t       c;
   logic        want;
   logic        conducting;
   logic        on_phase;
   logic [16:0] cur;
   logic [16:0] cont_lim;
   logic [17:0] cont_time;
   logic [13:0] arm;
   logic [7:0]  over_lim;
   logic [2:0]  cause;
   logic        restart;
   logic [1:0]  wr_ch;
   logic        chan_sel;
   status_t     st;
   applied_t    ap;

   always_comb begin
      next_s     = s;
      c          = '0;
      want       = 1'b0;
      conducting = 1'b0;
      on_phase   = 1'b0;
      cur        = '0;
      cont_lim   = '0;
      cont_time  = '0;
      arm        = '0;
      over_lim   = '0;
      cause      = '0;
      restart    = 1'b0;
      st         = '0;
      ap         = '0;
      wr_ch      = bus.addr[6:5];
      chan_sel   = !bus.addr[7] && (bus.addr[1:0] == 2'b00);

      // one-cycle tick enables from the shared dividers
      next_s.us_tick = s.us_div == 4'(US_CYCLES - 1);
      next_s.us_div  = next_s.us_tick ? 4'h0 : s.us_div + 4'h1;
      next_s.ms_tick = s.ms_div == 16'(MS_CYCLES - 1);
      next_s.ms_div  = next_s.ms_tick ? 16'h0000 : s.ms_div + 16'h0001;

      for (int i = 0; i < NUM_CH; i++) begin
         c          = s.ch[i];
         cur        = current[i];
         want       = c.ctl.on && type_ok[i];
         conducting = s.drv.high_side[i];
         cont_lim   = CONT_BASE_MA + 17'(c.ctl.cont_limit_sel) * CONT_STEP_MA;
         cont_time  = CONT_TIME_US[(c.ctl.cont_time_sel > 3'd5) ? 3'd5
                                                                : c.ctl.cont_time_sel];
         arm        = (c.tim.arming_ms > ARM_MAX_MS) ? ARM_MAX_MS : c.tim.arming_ms;
         over_lim   = (c.fuse.overshoot_ms < OVER_MIN_MS) ? OVER_MIN_MS :
                      (c.fuse.overshoot_ms > OVER_MAX_MS) ? OVER_MAX_MS : c.fuse.overshoot_ms;
         cause      = '0;
         restart    = 1'b0;

         // peak while conducting; a status read restarts it but keeps this sample
         if (bus.read && chan_sel && wr_ch == 2'(i)
             && bus.addr[4:2] == REG_STATUS) begin
            next_s.ch[i].peak = conducting ? cur : 17'h00000;
         end else if (conducting && cur > c.peak) begin
            next_s.ch[i].peak = cur;
         end

         unique case (c.fsm)
            CH_OFF: begin
               if (want) begin
                  next_s.ch[i].fsm = CH_ON;
                  restart = 1'b1;
               end
            end
            CH_ON: begin
               if (c.inrush_cnt != INRUSH_CYCLES) begin
                  next_s.ch[i].inrush_cnt = c.inrush_cnt + 8'h01;
               end
               if (s.us_tick && c.us_cnt != 18'h3ffff) begin
                  next_s.ch[i].us_cnt = c.us_cnt + 18'h00001;
               end
               if (s.ms_tick && c.ms_cnt != 14'h3fff) begin
                  next_s.ch[i].ms_cnt = c.ms_cnt + 14'h0001;
               end
               next_s.ch[i].phase = c.phase + phase_inc[i];
               if (conducting) begin
                  cause[0] = c.inrush_cnt == INRUSH_CYCLES && cur >= HIGH_LIMIT_MA;
                  cause[1] = c.us_cnt >= cont_time && cur >= cont_lim;
                  // steady check waits for both arming delay and continuous window
                  if (c.ms_cnt >= arm && c.us_cnt >= cont_time) begin
                     if (cur > c.fuse.steady_fuse_level) begin
                        if (s.ms_tick) begin
                           next_s.ch[i].over_cnt = c.over_cnt + 8'h01;
                        end
                        cause[2] = c.over_cnt >= over_lim;
                     end else begin
                        next_s.ch[i].over_cnt = 8'h00;
                     end
                  end
               end
               if (cause != 3'b000) begin
                  next_s.ch[i].cause    = cause;
                  next_s.ch[i].wait_cnt = 12'h000;
                  next_s.ch[i].phase    = 32'h00000000;
                  if (c.retries < c.tim.retry_max) begin
                     next_s.ch[i].fsm     = CH_RETRY;
                     next_s.ch[i].retries = c.retries + 4'h1;
                  end else begin
                     next_s.ch[i].fsm = CH_LOCKED;
                  end
               end
            end
            CH_RETRY: begin
               if (s.ms_tick) begin
                  next_s.ch[i].wait_cnt = c.wait_cnt + 12'h001;
               end
               if (c.wait_cnt >= c.tim.interval_ms) begin
                  next_s.ch[i].fsm = CH_ON;
                  restart = 1'b1;
               end
            end
            CH_LOCKED: begin
               next_s.ch[i].fsm = CH_LOCKED;
            end
            default: next_s.ch[i].fsm = CH_OFF;
         endcase

         if (restart) begin
            next_s.ch[i].inrush_cnt = 8'h00;
            next_s.ch[i].us_cnt     = 18'h00000;
            next_s.ch[i].ms_cnt     = 14'h0000;
            next_s.ch[i].over_cnt   = 8'h00;
            next_s.ch[i].phase      = 32'h00000000;
         end
         // dropping the command or selecting a type the channel cannot run is the only way out of the locked state
         if (!want) begin
            next_s.ch[i].fsm     = CH_OFF;
            next_s.ch[i].retries = 4'h0;
            next_s.ch[i].phase   = 32'h00000000;
         end

         on_phase = (duty_app[i] == DUTY_FULL) ||
                    ({1'b0, c.phase[31:16]} < 17'(duty_app[i]) * 17'(DUTY_SCALE));
         next_s.drv.high_side[i] = next_s.ch[i].fsm == CH_ON && c.fsm == CH_ON && on_phase;
         next_s.drv.low_side[i]  = !next_s.drv.high_side[i];
      end

      // lookup walks the channels: address y0, address y1, capture, store
      next_s.lk_step = s.lk_step + 2'd1;
      unique case (s.lk_step)
         2'd1: next_s.y0 = mem_rdata;
         2'd2: next_s.y1 = mem_rdata;
         2'd3: begin
            next_s.ch[s.lk_ch].map_out = lk_result;
            next_s.lk_ch = s.lk_ch + 2'd1;
         end
         default: ;
      endcase

      // register writes; reserved bits are masked so they read back as zero
      next_s.mem_we = 1'b0;
      if (bus.write && chan_sel) begin
         unique case (bus.addr[4:2])
            REG_CONTROL: next_s.ch[wr_ch].ctl  = control_t'(bus.wdata & CONTROL_MASK);
            REG_FUSE:    next_s.ch[wr_ch].fuse = fuse_t'(bus.wdata & FUSE_MASK);
            REG_TIMING:  next_s.ch[wr_ch].tim  = timing_t'(bus.wdata & TIMING_MASK);
            REG_PWM:     next_s.ch[wr_ch].pwm  = pwm_cfg_t'(bus.wdata & PWM_MASK);
            REG_MAP:     next_s.ch[wr_ch].map  = map_cfg_t'(bus.wdata & MAP_MASK);
            default: ;
         endcase
      end
      if (bus.write && bus.addr == MAP_WRITE_ADDR) begin
         next_s.mem_we    = 1'b1;
         next_s.mem_waddr = bus.wdata[21:16];
         next_s.mem_wdata = bus.wdata[15:0];
      end

      // read data stand for exactly one cycle, zero otherwise
      st.fsm     = s.ch[wr_ch].fsm;
      st.retries = s.ch[wr_ch].retries;
      st.cause   = s.ch[wr_ch].cause;
      st.peak_ma = s.ch[wr_ch].peak;
      ap.freq_hz  = freq_app[wr_ch];
      ap.duty_pct = duty_app[wr_ch];
      next_s.rdata = 32'h00000000;
      if (bus.read && chan_sel) begin
         unique case (bus.addr[4:2])
            REG_CONTROL: next_s.rdata = s.ch[wr_ch].ctl;
            REG_FUSE:    next_s.rdata = s.ch[wr_ch].fuse;
            REG_TIMING:  next_s.rdata = s.ch[wr_ch].tim;
            REG_PWM:     next_s.rdata = s.ch[wr_ch].pwm;
            REG_MAP:     next_s.rdata = s.ch[wr_ch].map;
            REG_STATUS:  next_s.rdata = st;
            REG_APPLIED: next_s.rdata = ap;
            default: ;
         endcase
      end
   end

   // ==================================================================
   // registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.drv.low_side <= '1;
         for (int i = 0; i < NUM_CH; i++) begin
            s.ch[i].fsm  <= CH_OFF;
            s.ch[i].fuse <= FUSE_RESET;
            s.ch[i].tim  <= TIMING_RESET;
            s.ch[i].pwm  <= PWM_RESET;
         end
      end else begin
         s <= next_s;
      end
   end

   assign read_data = s.rdata;
   assign drive     = s.drv;
   for (genvar gf = 0; gf < NUM_CH; gf++) begin : g_fault
      assign channel_fault[gf] = s.ch[gf].fsm == CH_RETRY || s.ch[gf].fsm == CH_LOCKED;
   end
endmodule
`default_nettype wire

// File: shared/pwm_efuse_pkg.sv
/*
  Shared constants and types for the four-channel pwm output block with
  electronic fuses. Assumes a 10 MHz clock and mA current samples.
*/
`default_nettype none
package pwm_efuse_pkg;
   // ==================================================================
   // sizes and timing
   localparam int NUM_CH            = 4;
   localparam int CLOCK_HZ          = 10_000_000;
   localparam int US_CYCLES         = CLOCK_HZ / 1_000_000;
   localparam int MS_CYCLES_DEFAULT = CLOCK_HZ / 1_000;
   localparam int INRUSH_US         = 20;
   localparam logic [7:0] INRUSH_CYCLES = 8'(INRUSH_US * US_CYCLES);
   localparam logic [17:0] CONT_TIME_US [6] = '{18'd150, 18'd1200, 18'd10000,
                                                18'd25000, 18'd50000, 18'd155000};
   localparam logic [13:0] ARM_MAX_MS    = 14'd10000;
   localparam logic [7:0]  OVER_MIN_MS   = 8'd25;
   localparam logic [7:0]  OVER_MAX_MS   = 8'd250;
   // ==================================================================
   // currents and pwm figures
   localparam logic [16:0] HIGH_LIMIT_MA = 17'd75000;
   localparam logic [16:0] CONT_BASE_MA  = 17'd7500;
   localparam logic [16:0] CONT_STEP_MA  = 17'd2500;
   localparam logic [14:0] FREQ_MIN_HZ   = 15'd30;
   localparam logic [14:0] FREQ_MAX_HZ   = 15'd25000;
   localparam logic [6:0]  DUTY_FULL     = 7'd100;
   localparam logic [15:0] DUTY_SCALE    = 16'd655;
   localparam logic [24:0] PHASE_SCALE   = 25'((64'd1 << 48) / CLOCK_HZ);
   // ==================================================================
   // register map: addr[7] global, addr[6:5] channel, addr[4:2] index
   localparam logic [2:0] REG_CONTROL = 3'd0;
   localparam logic [2:0] REG_FUSE    = 3'd1;
   localparam logic [2:0] REG_TIMING  = 3'd2;
   localparam logic [2:0] REG_PWM     = 3'd3;
   localparam logic [2:0] REG_MAP     = 3'd4;
   localparam logic [2:0] REG_STATUS  = 3'd5;
   localparam logic [2:0] REG_APPLIED = 3'd6;
   localparam logic [7:0] MAP_WRITE_ADDR = 8'h80;
   // ==================================================================
   // types
   typedef enum logic [3:0] {
      PWM_NONE    = 4'h0, DIG_OUT   = 4'h1,
      DUTY_INTERP = 4'h4, DUTY_DOWN = 4'h5, DUTY_UP = 4'h6, DUTY_NEAR = 4'h7,
      FREQ_INTERP = 4'h8, FREQ_DOWN = 4'h9, FREQ_UP = 4'ha, FREQ_NEAR = 4'hb
   } pwm_type_t;
   typedef enum logic [3:0] {
      CH_OFF = 4'b0001, CH_ON = 4'b0010, CH_RETRY = 4'b0100, CH_LOCKED = 4'b1000
   } chan_fsm_t;
   typedef struct packed {
      logic [17:0] unused; logic [2:0] cont_time_sel; logic [2:0] cont_limit_sel;
      pwm_type_t pwm_type; logic [2:0] spare; logic on;
   } control_t;
   typedef struct packed {
      logic [7:0] overshoot_ms; logic [6:0] unused; logic [16:0] steady_fuse_level;
   } fuse_t;
   typedef struct packed {
      logic [11:0] interval_ms; logic [3:0] retry_max; logic [1:0] unused;
      logic [13:0] arming_ms;
   } timing_t;
   typedef struct packed {
      logic unused; logic [14:0] freq_hz; logic [8:0] spare; logic [6:0] duty_pct;
   } pwm_cfg_t;
   typedef struct packed {
      logic [11:0] unused; logic [3:0] axis_shift; logic [15:0] map_input;
   } map_cfg_t;
   typedef struct packed {
      logic [2:0] unused; logic [16:0] peak_ma; logic [2:0] cause; logic spare;
      logic [3:0] retries; chan_fsm_t fsm;
   } status_t;
   typedef struct packed {
      logic unused; logic [14:0] freq_hz; logic [8:0] spare; logic [6:0] duty_pct;
   } applied_t;
   localparam logic [31:0] CONTROL_MASK = 32'h00003ff1;
   localparam logic [31:0] FUSE_MASK    = 32'hff01ffff;
   localparam logic [31:0] TIMING_MASK  = 32'hffff3fff;
   localparam logic [31:0] PWM_MASK     = 32'h7fff007f;
   localparam logic [31:0] MAP_MASK     = 32'h000fffff;
   localparam fuse_t    FUSE_RESET   = '{overshoot_ms: 8'd25, unused: '0,
                                         steady_fuse_level: 17'd5000};
   localparam timing_t  TIMING_RESET = '{interval_ms: 12'd250, retry_max: 4'd3,
                                         unused: '0, arming_ms: 14'd500};
   localparam pwm_cfg_t PWM_RESET    = '{unused: 1'b0, freq_hz: 15'd150, spare: '0,
                                         duty_pct: 7'd50};
   typedef struct packed {
      logic [7:0] addr; logic [31:0] wdata; logic write; logic read;
   } reg_req_t;
   typedef logic [NUM_CH-1:0][16:0] current_t;
   typedef struct packed {
      logic [NUM_CH-1:0] high_side; logic [NUM_CH-1:0] low_side;
   } drive_t;
endpackage
`default_nettype wire

// File: verification/load_model.sv
/* load model for the four outputs; assumes a resistive load fed from the bench */
`timescale 1ns/1ps
`default_nettype none
module load_model
   import pwm_efuse_pkg::*;
(
   input  wire pwm_efuse_pkg::drive_t   drive,
   input  wire pwm_efuse_pkg::current_t level,
   output var  pwm_efuse_pkg::current_t current
);
   // ====================
   // no conduction, no current: the sense reads zero while the low side holds
   always_comb
      for (int i = 0; i < NUM_CH; i++)
         current[i] = drive.high_side[i] ? level[i] : 17'h0;
endmodule
`default_nettype wire

// File: verification/pwm_efuse_assertions.sv
/* port checker for the pwm fuse block; assumes one clock and async reset_n */
`timescale 1ns/1ps
`default_nettype none
module pwm_efuse_checker
   import pwm_efuse_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEFAULT
) (
   input wire logic                    clock,
   input wire logic                    reset_n,
   input wire pwm_efuse_pkg::reg_req_t bus,
   input wire logic [31:0]             read_data,
   input wire pwm_efuse_pkg::current_t current,
   input wire pwm_efuse_pkg::drive_t   drive,
   input wire logic [3:0]              channel_fault
);
   // ====================
   // cycles channel 0 has conducted; only digital type is checked this way
   logic [15:0] on_cnt;
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
         on_cnt <= '0;
      else
         on_cnt <= drive.high_side[0] ? on_cnt + 16'd1 : '0;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_BRIDGE_SIDES: assert property (drive.low_side == ~drive.high_side)
      else $error("bridge sides not complementary");
   AST_READ_IDLE: assert property (!$past(bus.read) |-> read_data == 32'h0)
      else $error("read data outside its cycle");
   AST_INRUSH_HOLD: assert property ($rose(channel_fault[0]) |->
      on_cnt + 16'd2 > 16'(INRUSH_CYCLES))
      else $error("trip inside inrush window");
   AST_HIGH_TRIP: assert property (drive.high_side[0] && current[0] >= HIGH_LIMIT_MA &&
      on_cnt + 16'd2 > 16'(INRUSH_CYCLES) |-> ##[1:3] channel_fault[0])
      else $error("high current not tripped");
   AST_FAULT_OPENS: assert property (!(|($past(channel_fault) & drive.high_side)))
      else $error("faulted channel still conducting");
   AST_RETRY_WAIT: assert property ($rose(channel_fault[0]) |-> channel_fault[0] [*8])
      else $error("retry came too soon");
   AST_RESET_SAFE: assert property ($rose(reset_n) |->
      drive.high_side == 4'h0 && channel_fault == 4'h0)
      else $error("outputs not safe after reset");
   AST_FAULT_SOURCE: assert property ($rose(channel_fault[0]) |->
      $past(drive.high_side[0]))
      else $error("fault without conduction");
endmodule
bind pwm_output_efuse_channel pwm_efuse_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock(clock),
   .reset_n(reset_n), .bus(bus), .read_data(read_data), .current(current), .drive(drive),
   .channel_fault(channel_fault));
`default_nettype wire

// File: verification/tb.sv
/* bench for the pwm fuse block; a load model closes the current loop */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pwm_efuse_pkg::*;
   // ====================
   logic        clock;
   logic        reset_n;
   reg_req_t    bus;
   logic [31:0] read_data;
   logic [31:0] d;
   current_t    current;
   current_t    level;
   drive_t      drive;
   logic [3:0]  channel_fault;
   int          n_mismatch;
   int          checks_done;
   // reset values of both ends of the map, then a hole in it
   logic [39:0] rows [5] = '{{8'h04, 32'h19001388}, {8'h08, 32'h0fa301f4},
      {8'h6c, 32'h00960032}, {8'h74, 32'h00000001}, {8'h1c, 32'h0}};
   pwm_output_efuse_channel #(.MS_CYCLES(20)) DUT (.clock(clock), .reset_n(reset_n), .bus(bus),
      .read_data(read_data), .current(current), .drive(drive), .channel_fault(channel_fault));
   load_model u_load (.drive(drive), .level(level), .current(current));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      bus <= '{a, v, w, !w};
      @(posedge clock);
      bus <= '{a, v, 1'b0, 1'b0};
      #1 d = read_data;
   endtask
   task automatic wait_fault(input logic v);
      int k;
      for (k = 0; k < 3000 && channel_fault[0] !== v; k++)
         @(negedge clock);
      if (k == 3000) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      bus = '0;
      level = '0;
      reset_n = 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      #1 chk(32'(drive), 32'h0f);
      for (int r = 0; r < 5; r++) begin
         acc(1'b0, rows[r][39:32], 32'h0);
         chk(d, rows[r][31:0]);
      end
      acc(1'b1, 8'h0c, 32'h000a0032);
      repeat (20) @(posedge clock);
      acc(1'b0, 8'h18, 32'h0);
      chk(d, 32'h001e0032);
      acc(1'b0, 8'h38, 32'h0);
      chk(d, 32'h001e0032);
      acc(1'b1, 8'h20, 32'h00000081);
      repeat (4) @(posedge clock);
      #1 chk(32'(drive.high_side[1]), 32'h0);
      acc(1'b1, 8'h80, 32'h00210014);
      acc(1'b1, 8'h80, 32'h00220028);
      acc(1'b1, 8'h80, 32'h00300064);
      acc(1'b1, 8'h80, 32'h0031012c);
      acc(1'b1, 8'h50, 32'h00040018);
      acc(1'b1, 8'h70, 32'h00040008);
      acc(1'b1, 8'h40, 32'h00000040);
      acc(1'b1, 8'h60, 32'h00000080);
      repeat (20) @(posedge clock);
      acc(1'b0, 8'h58, 32'h0);
      chk(d, 32'h0096001e);
      acc(1'b0, 8'h78, 32'h0);
      chk(d, 32'h00c80032);
      acc(1'b1, 8'h40, 32'h00000070);
      acc(1'b1, 8'h60, 32'h00000090);
      repeat (20) @(posedge clock);
      acc(1'b0, 8'h58, 32'h0);
      chk(d, 32'h00960028);
      acc(1'b0, 8'h78, 32'h0);
      chk(d, 32'h00640032);
      level[0] <= 17'd80000;
      acc(1'b1, 8'h08, 32'h002101f4);
      acc(1'b1, 8'h00, 32'h00000011);
      repeat (150) @(posedge clock);
      #1 chk(32'(drive.high_side[0]), 32'h1);
      wait_fault(1'b1);
      acc(1'b0, 8'h14, 32'h0);
      chk(d & 32'hfff, 32'h214);
      chk(d >> 12, 32'h13880);
      wait_fault(1'b0);
      wait_fault(1'b1);
      repeat (40) @(posedge clock);
      acc(1'b0, 8'h14, 32'h0);
      chk(d & 32'hf, 32'h8);
      acc(1'b0, 8'h18, 32'h0);
      chk(d, 32'h001e0064);
      acc(1'b1, 8'h00, 32'h00000010);
      repeat (3) @(posedge clock);
      #1 chk({28'h0, channel_fault}, 32'h0);
      level[0] <= 17'd10000;
      acc(1'b1, 8'h00, 32'h00000011);
      wait_fault(1'b1);
      acc(1'b0, 8'h14, 32'h0);
      chk(d & 32'hfff, 32'h414);
      acc(1'b1, 8'h00, 32'h00000010);
      level[0] <= 17'd6500;
      acc(1'b1, 8'h04, 32'h19001770);
      acc(1'b1, 8'h08, 32'h00210050);
      acc(1'b1, 8'h00, 32'h00000011);
      wait_fault(1'b1);
      acc(1'b0, 8'h14, 32'h0);
      chk(d & 32'hfff, 32'h814);
      finish_test();
   end
endmodule
`default_nettype wire
